// file: verilog/cglps_pkg.sv
// Package of constants for the clock generation and low-power stop block
package cglps_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CLKOUT = 8'h00;
	localparam logic [7:0] OFS_PLL_CONTROL_REG = 8'h04;
	localparam logic [7:0] OFS_CDIV = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_MODSTOP = 8'h10;
	localparam logic [7:0] OFS_KEY = 8'h14;
	// Unlock key written to the key register before a guarded write
	localparam logic [31:0] UNLOCK_KEY = 32'h0000_00A5;
	// Multiplier reset values per mode
	localparam logic [11:0] MF_RST_XTAL = 12'h191; // 401
	localparam logic [11:0] MF_RST_DIRECT = 12'h002;
	// Divider field positions in the divider register, and the STSIM bit of the PLL control register
	localparam int DIV_SYNC_LSB = 0;
	localparam int DIV_BRG_LSB = 4;
	localparam int DIV_LO_LSB = 8;
	localparam int DIV_HI_LSB = 12;
	localparam int DIV_THR_LSB = 16;
	localparam int DIV_RRQ_BIT = 19;
	localparam int DIV_SLOW_BIT = 20;
	localparam int DIV_WP_BIT = 31;
	localparam int PLL_STSIM_BIT = 12;
	localparam logic [3:0] DIV_RST = 4'h0; // Divide by one
	localparam logic [6:0] PRESCALE_LAST = 7'h7F; // Divide by 128
	// Edges after reset before the synchronised straps are valid
	localparam logic [1:0] STRAP_AGE = 2'h2;
	// Relock time in reference clocks, worst case
	localparam int RELOCK_REFS = 2500;
	localparam logic [11:0] RELOCK_CNT = 12'(RELOCK_REFS - 1);
endpackage : cglps_pkg

// file: verilog/cglps_top.sv
// Clock generation and low-power stop control with AHB-Lite registers
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module cglps_top (
	input wire logic hclk, // Bus clock, 250 MHz
	input wire logic hresetn, // Async reset, low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write flag
	input wire logic [2:0] hsize, // Size
	input wire logic hready, // Bus ready
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	input wire logic [1:0] clock_mode_pins, // Mode straps
	input wire logic oscillator_input, // Oscillator, sampled
	input wire logic low_power_stop_instr, // Core requests stop
	input wire logic ordinary_stop, // Core ordinary stop
	input wire logic bus_halt_n, // External halt, low
	input wire logic wake_irq, // Interrupt ending stop
	input wire logic [2:0] pending_irq_level, // Pending interrupt level
	input wire logic risc_busy, // RISC has work
	input wire logic [7:0] sub_block_active, // Sub-block activity
	output logic lp_stop_active, // Stop is in effect
	output logic watchdog_clk_en, // Watchdog clock enable
	output logic pit_clk_en, // Periodic timer clock enable
	output logic monitors_en, // Bus monitors enable
	output logic timer_ref_clock, // Timer reference tick
	output logic prescaled_ref_clock, // PLL reference tick
	output logic pll_locked, // Lock detect
	output logic [11:0] pll_multiplier_field, // Active multiplier
	output logic sys_clk_en, // General system clock enable
	output logic serial_sync_clock, // Sync clock enable
	output logic baud_gen_clock, // Baud clock enable
	output logic [7:0] sub_clk_en, // Sub-block core clock enables
	output logic [7:0] bus_if_clk_en // Sub-block bus interface enables
);
	typedef enum logic [1:0] {
		CGLPS_RUN,
		CGLPS_WAITHALT,
		CGLPS_STOP
	} cglps_pwr_e;

	typedef struct packed {
		logic [1:0] osc_sync;
		logic osc_prev;
		logic [1:0] mode_s1;
		logic [1:0] mode_s2;
		logic [1:0] strap_age;
		logic strap_done;
		logic div128;
		logic [6:0] pre_cnt;
		logic [1:0] halt_s;
		logic [1:0] wake_s;
		logic [31:0] clkout_reg;
		logic [11:0] mf;
		logic stsim;
		logic [31:0] cdiv;
		logic [7:0] modstop;
		logic unlocked;
		logic [11:0] lock_cnt;
		logic locked;
		logic [3:0] sys_cnt;
		logic [3:0] sync_cnt;
		logic [3:0] brg_cnt;
		logic [3:0] sys_div;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] rdata;
		cglps_pwr_e pwr;
		logic ref_tick;
		logic tmr_tick;
	} cglps_state_s;

	cglps_state_s st_r;
	cglps_state_s st_nxt;

	// Divider counter step; returns the tick flag for a divide ratio
	function automatic logic cglps_div_tick(input logic [3:0] cnt,
			input logic [3:0] ratio);
		cglps_div_tick = (cnt >= ratio);
	endfunction : cglps_div_tick

	function automatic logic [3:0] cglps_div_next(input logic [3:0] cnt,
			input logic [3:0] ratio);
		cglps_div_next = (cnt >= ratio) ? 4'h0 : 4'(cnt + 4'h1);
	endfunction : cglps_div_next

	logic osc_rise;
	logic guarded_ok;
	logic boost;
	logic [3:0] want_sys;

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		// Oscillator and strap synchronisers
		st_nxt.osc_sync = {st_r.osc_sync[0], oscillator_input};
		st_nxt.osc_prev = st_r.osc_sync[1];
		st_nxt.mode_s1 = clock_mode_pins;
		st_nxt.mode_s2 = st_r.mode_s1;
		st_nxt.halt_s = {st_r.halt_s[0], bus_halt_n};
		st_nxt.wake_s = {st_r.wake_s[0], wake_irq};
		osc_rise = st_r.osc_sync[1] & ~st_r.osc_prev;
		// Catch straps once, after the synchroniser has filled
		if (!st_r.strap_done) begin
			st_nxt.strap_age = 2'(st_r.strap_age + 2'h1);
			if (st_r.strap_age == cglps_pkg::STRAP_AGE) begin
				st_nxt.strap_done = 1'b1;
				st_nxt.div128 = ~st_r.mode_s2[0];
				st_nxt.mf = st_r.mode_s2[1] ? cglps_pkg::MF_RST_DIRECT
					: cglps_pkg::MF_RST_XTAL;
			end
		end
		// Prescaler: every rising oscillator edge, or one in 128
		st_nxt.ref_tick = 1'b0;
		st_nxt.tmr_tick = 1'b0;
		if (osc_rise) begin
			st_nxt.pre_cnt = 7'(st_r.pre_cnt + 7'h01);
			if (!st_r.div128 || st_r.pre_cnt == cglps_pkg::PRESCALE_LAST) begin
				st_nxt.ref_tick = 1'b1;
				st_nxt.tmr_tick = 1'b1;
			end
		end
		// Relock counter counts reference ticks
		if (!st_r.locked && st_r.ref_tick) begin
			if (st_r.lock_cnt == cglps_pkg::RELOCK_CNT)
				st_nxt.locked = 1'b1;
			else
				st_nxt.lock_cnt = 12'(st_r.lock_cnt + 12'h001);
		end
		// Bus address phase capture
		st_nxt.ap_valid = hsel & hready & htrans[1];
		st_nxt.ap_write = hwrite;
		st_nxt.ap_addr = haddr[7:0];
		guarded_ok = st_r.unlocked;
		// Data phase write
		if (st_r.ap_valid && st_r.ap_write) begin
			st_nxt.unlocked = 1'b0;
			unique case (st_r.ap_addr)
				cglps_pkg::OFS_KEY:
					st_nxt.unlocked = (hwdata == cglps_pkg::UNLOCK_KEY);
				cglps_pkg::OFS_CLKOUT:
					if (guarded_ok) st_nxt.clkout_reg = hwdata;
				cglps_pkg::OFS_PLL_CONTROL_REG:
					if (guarded_ok) begin
						st_nxt.stsim = hwdata[cglps_pkg::PLL_STSIM_BIT];
						if (hwdata[11:0] != st_r.mf) begin
							st_nxt.mf = hwdata[11:0];
							st_nxt.locked = 1'b0;
							st_nxt.lock_cnt = 12'h000;
						end
					end
				cglps_pkg::OFS_CDIV:
					if (guarded_ok && !st_r.cdiv[cglps_pkg::DIV_WP_BIT])
						st_nxt.cdiv = hwdata;
				cglps_pkg::OFS_MODSTOP: st_nxt.modstop = hwdata[7:0];
				default: ;
			endcase
		end
		// Read data register for the next data phase
		st_nxt.rdata = 32'h0000_0000;
		if (hsel && hready && htrans[1] && !hwrite) begin
			unique case (haddr[7:0])
				cglps_pkg::OFS_CLKOUT: st_nxt.rdata = st_r.clkout_reg;
				cglps_pkg::OFS_PLL_CONTROL_REG:
					st_nxt.rdata = {19'h00000, st_r.stsim, st_r.mf};
				cglps_pkg::OFS_CDIV: st_nxt.rdata = st_r.cdiv;
				cglps_pkg::OFS_STATUS:
					st_nxt.rdata = {27'h0000000, st_r.unlocked, st_r.div128,
						st_r.pwr == CGLPS_STOP, st_r.pwr == CGLPS_WAITHALT,
						st_r.locked};
				cglps_pkg::OFS_MODSTOP: st_nxt.rdata = {24'h000000, st_r.modstop};
				default: st_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Low-power stop sequencing
		unique case (st_r.pwr)
			CGLPS_RUN:
				if (low_power_stop_instr)
					st_nxt.pwr = st_r.halt_s[1] ? CGLPS_STOP : CGLPS_WAITHALT;
			CGLPS_WAITHALT:
				if (st_r.halt_s[1]) st_nxt.pwr = CGLPS_STOP;
			CGLPS_STOP:
				if (st_r.wake_s[1]) st_nxt.pwr = CGLPS_RUN;
		endcase
		// Slow-go select: boost to high divide on interrupt or busy RISC
		boost = (pending_irq_level > st_r.cdiv[cglps_pkg::DIV_THR_LSB +: 3])
			| (st_r.cdiv[cglps_pkg::DIV_RRQ_BIT] & risc_busy);
		want_sys = !st_r.cdiv[cglps_pkg::DIV_SLOW_BIT] ? cglps_pkg::DIV_RST
			: boost ? st_r.cdiv[cglps_pkg::DIV_HI_LSB +: 4]
			: st_r.cdiv[cglps_pkg::DIV_LO_LSB +: 4];
		// Ratio swaps only at a division boundary
		if (cglps_div_tick(st_r.sys_cnt, st_r.sys_div))
			st_nxt.sys_div = want_sys;
		st_nxt.sys_cnt = cglps_div_next(st_r.sys_cnt, st_r.sys_div);
		st_nxt.sync_cnt = cglps_div_next(st_r.sync_cnt,
			st_r.cdiv[cglps_pkg::DIV_SYNC_LSB +: 4]);
		st_nxt.brg_cnt = cglps_div_next(st_r.brg_cnt,
			st_r.cdiv[cglps_pkg::DIV_BRG_LSB +: 4]);
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= '0;
			st_r.mf <= cglps_pkg::MF_RST_XTAL;
			st_r.pwr <= CGLPS_RUN;
			st_r.cdiv <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	logic stopped;
	logic run_ok;
	assign stopped = (st_r.pwr == CGLPS_STOP);
	assign run_ok = st_r.locked & st_r.strap_done & ~stopped;

	// Bus answers: zero wait states, OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_r.rdata;

	// Stop effects on timers and monitors
	assign lp_stop_active = stopped;
	assign watchdog_clk_en = st_r.tmr_tick & ~stopped;
	assign pit_clk_en = st_r.tmr_tick;
	assign monitors_en = run_ok;
	assign timer_ref_clock = st_r.tmr_tick;
	assign prescaled_ref_clock = st_r.ref_tick;
	assign pll_locked = st_r.locked;
	assign pll_multiplier_field = st_r.mf;

	// Derived clock enables, all held while unlocked or stopped
	assign sys_clk_en = run_ok & cglps_div_tick(st_r.sys_cnt, st_r.sys_div);
	assign serial_sync_clock = run_ok & cglps_div_tick(st_r.sync_cnt,
		st_r.cdiv[cglps_pkg::DIV_SYNC_LSB +: 4]);
	assign baud_gen_clock = run_ok & cglps_div_tick(st_r.brg_cnt,
		st_r.cdiv[cglps_pkg::DIV_BRG_LSB +: 4]);
	// Sub-block core clocks stop when idle or when their stop bit is set; bus interface clocks follow sys_clk_en only
	assign sub_clk_en = {8{sys_clk_en}} & sub_block_active
		& ~st_r.modstop;
	assign bus_if_clk_en = {8{sys_clk_en}};
endmodule : cglps_top

// file: dv/cglps_properties.sv
// Port-level checker for the clock generation and stop block
`timescale 1ns/1ps
module cglps_properties (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, low
	input wire logic hreadyout, // Slave ready
	input wire logic hresp, // Response
	input wire logic bus_halt_n, // External halt, low
	input wire logic lp_stop_active, // Stop in effect
	input wire logic watchdog_clk_en, // Watchdog enable
	input wire logic pit_clk_en, // Timer enable
	input wire logic monitors_en, // Monitors enable
	input wire logic timer_ref_clock, // Timer tick
	input wire logic pll_locked, // Lock detect
	input wire logic [11:0] pll_multiplier_field, // Multiplier
	input wire logic sys_clk_en, // System enable
	input wire logic serial_sync_clock, // Sync enable
	input wire logic baud_gen_clock, // Baud enable
	input wire logic [7:0] sub_block_active, // Activity
	input wire logic [7:0] sub_clk_en, // Core enables
	input wire logic [7:0] bus_if_clk_en // Interface enables
);
	// All checks run on the bus clock
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not OKAY");
	a_stop_wdog: assert property (lp_stop_active |-> !watchdog_clk_en)
		else $error("watchdog clocked in stop");
	a_stop_mons: assert property (lp_stop_active |-> !monitors_en)
		else $error("monitors active in stop");
	a_halt_holds: assert property (
		(!bus_halt_n && !lp_stop_active)[*4] |=> !lp_stop_active)
		else $error("stop entered while halted");
	a_idle_gated: assert property (
		(sub_clk_en & ~sub_block_active) == 8'h00)
		else $error("idle sub-block clocked");
	a_busif_kept: assert property ((sub_clk_en & ~bus_if_clk_en) == 8'h00)
		else $error("bus interface gated");
	a_lock_gates: assert property (!pll_locked |->
		!(sys_clk_en || serial_sync_clock || baud_gen_clock))
		else $error("clock while unlocked");
	a_pit_free: assert property (timer_ref_clock |-> pit_clk_en)
		else $error("timer tick lost");
	a_mf_relock: assert property ($changed(pll_multiplier_field) |->
		##[0:2] !pll_locked)
		else $error("lock kept on multiplier change");
	a_wdog_runs: assert property (
		timer_ref_clock && !lp_stop_active |-> watchdog_clk_en)
		else $error("watchdog tick lost outside stop");
	// Main scenarios reached
	c_stop: cover property ($rose(lp_stop_active));
	c_unlock: cover property ($fell(pll_locked));
	c_pit_stop: cover property (lp_stop_active && pit_clk_en);
endmodule : cglps_properties

bind cglps_top cglps_properties u_props (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .bus_halt_n(bus_halt_n),
	.lp_stop_active(lp_stop_active), .watchdog_clk_en(watchdog_clk_en),
	.pit_clk_en(pit_clk_en), .monitors_en(monitors_en),
	.timer_ref_clock(timer_ref_clock), .pll_locked(pll_locked),
	.pll_multiplier_field(pll_multiplier_field), .sys_clk_en(sys_clk_en),
	.serial_sync_clock(serial_sync_clock), .baud_gen_clock(baud_gen_clock),
	.sub_block_active(sub_block_active), .sub_clk_en(sub_clk_en),
	.bus_if_clk_en(bus_if_clk_en));

// file: dv/cglps_osc_model.sv
// Free-running external oscillator model
`timescale 1ns/1ps
module cglps_osc_model #(parameter realtime half_ns = 12.0) (
	output logic oscillator_input // Oscillator output
);
	// Runs free, phase unrelated to the bus clock
	initial begin
		oscillator_input = 1'b0;
		#5.3;
		forever #(half_ns) oscillator_input = ~oscillator_input;
	end
endmodule : cglps_osc_model

// file: dv/cglps_top_tb.sv
// Self-checking bench for the clock generation and stop block
`timescale 1ns/1ps
module cglps_top_tb;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic low_power_stop_instr = 1'b0, ordinary_stop = 1'b0, rd_ph = 1'b0;
	logic bus_halt_n = 1'b1, wake_irq = 1'b0, risc_busy = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
	logic [31:0] seed = 32'hE1CDDA69;
	logic [1:0] htrans = 2'h0, clock_mode_pins = 2'h1;
	logic [2:0] pending_irq_level = 3'h0;
	logic [7:0] sub_block_active = 8'h00, sub_clk_en, bus_if_clk_en;
	logic [11:0] pll_multiplier_field;
	logic hreadyout, hresp, lp_stop_active, watchdog_clk_en, pit_clk_en;
	logic monitors_en, timer_ref_clock, prescaled_ref_clock, pll_locked;
	logic sys_clk_en, serial_sync_clock, baud_gen_clock, oscillator_input;
	logic [31:0] exp_q[$];
	int n_mismatch = 0, num_checks = 0, n_pit = 0, n_wd = 0;
	int n_ref = 0, n_sys = 0;
	wire hready = hreadyout;
	cglps_osc_model u_osc (.oscillator_input(oscillator_input));
	cglps_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.clock_mode_pins(clock_mode_pins), .oscillator_input(oscillator_input),
		.low_power_stop_instr(low_power_stop_instr),
		.ordinary_stop(ordinary_stop), .bus_halt_n(bus_halt_n),
		.wake_irq(wake_irq), .pending_irq_level(pending_irq_level),
		.risc_busy(risc_busy), .sub_block_active(sub_block_active),
		.lp_stop_active(lp_stop_active), .watchdog_clk_en(watchdog_clk_en),
		.pit_clk_en(pit_clk_en), .monitors_en(monitors_en),
		.timer_ref_clock(timer_ref_clock),
		.prescaled_ref_clock(prescaled_ref_clock), .pll_locked(pll_locked),
		.pll_multiplier_field(pll_multiplier_field), .sys_clk_en(sys_clk_en),
		.serial_sync_clock(serial_sync_clock), .baud_gen_clock(baud_gen_clock),
		.sub_clk_en(sub_clk_en), .bus_if_clk_en(bus_if_clk_en));
	// Bus clock, 4 ns period
	always #2 hclk = ~hclk;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer: address phase, then data phase
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (!hreadyout) @(posedge hclk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask : rd
	task automatic wr_key(input logic [7:0] a, input logic [31:0] d);
		bus(cglps_pkg::OFS_KEY, 1'b1, cglps_pkg::UNLOCK_KEY);
		bus(a, 1'b1, d);
	endtask : wr_key
	task automatic wait_lock();
		for (int i = 0; i < 20000 && pll_locked !== 1'b1; i++) @(posedge hclk);
	endtask : wait_lock
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	// Read data taken at the edge closing the data phase
	always @(posedge hclk) begin
		if (rd_ph) chk(hrdata, exp_q.pop_front());
		rd_ph <= hsel && htrans[1] && !hwrite && hreadyout;
		if (pit_clk_en === 1'b1) n_pit++;
		if (watchdog_clk_en === 1'b1) n_wd++;
		if (prescaled_ref_clock === 1'b1) n_ref++;
		if (sys_clk_en === 1'b1) n_sys++;
		seed = xs(seed);
		{pending_irq_level, risc_busy, sub_block_active} <= seed[11:0];
	end
	// Hang guard
	initial begin
		repeat (60000) @(posedge hclk);
		n_mismatch++;
		$display("BAD %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk(pll_multiplier_field, 32'h191);
		rd(cglps_pkg::OFS_PLL_CONTROL_REG, 32'h191);
		rd(cglps_pkg::OFS_CDIV, 32'h0);
		rd(8'h20, 32'h0);
		wait_lock();
		chk(pll_locked, 32'h1);
		n_sys = 0;
		repeat (10) @(posedge hclk);
		chk(32'(n_sys >= 10), 32'h1);
		bus(cglps_pkg::OFS_CDIV, 1'b1, 32'h1);
		rd(cglps_pkg::OFS_CDIV, 32'h0);
		v = seed & 32'h001F_FFFF;
		wr_key(cglps_pkg::OFS_CDIV, v);
		rd(cglps_pkg::OFS_CDIV, v);
		wr_key(cglps_pkg::OFS_CDIV, v | 32'h8000_0000);
		wr_key(cglps_pkg::OFS_CDIV, 32'h0);
		rd(cglps_pkg::OFS_CDIV, v | 32'h8000_0000);
		wr_key(cglps_pkg::OFS_PLL_CONTROL_REG, 32'h10);
		repeat (4) @(posedge hclk);
		chk(pll_locked, 32'h0);
		chk(pll_multiplier_field, 32'h10);
		wait_lock();
		chk(pll_locked, 32'h1);
		// Halt goes low first so its synchroniser settles before the request
		bus_halt_n <= 1'b0;
		repeat (3) @(posedge hclk);
		// Timer left running and no DMA to disable before stop
		low_power_stop_instr <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(lp_stop_active, 32'h0);
		bus_halt_n <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(lp_stop_active, 32'h1);
		n_pit = 0;
		n_ref = 0;
		repeat (200) @(posedge hclk);
		chk(32'(n_pit > 0), 32'h1);
		chk(32'(n_ref > 20), 32'h1);
		low_power_stop_instr <= 1'b0;
		wake_irq <= 1'b1;
		repeat (10) @(posedge hclk);
		chk(lp_stop_active, 32'h0);
		wake_irq <= 1'b0;
		ordinary_stop <= 1'b1;
		n_wd = 0;
		repeat (200) @(posedge hclk);
		chk(32'(n_wd > 0), 32'h1);
		// Second reset: direct clock with the divide-by-128 strap
		hresetn <= 1'b0;
		clock_mode_pins <= 2'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(pll_multiplier_field, 32'h2);
		rd(cglps_pkg::OFS_STATUS, 32'h8);
		rd(cglps_pkg::OFS_CDIV, 32'h0);
		// Divide-by-128 prescaler: fewer than two reference and timer ticks in 200 cycles
		n_pit = 0;
		n_ref = 0;
		repeat (200) @(posedge hclk);
		chk(32'(n_ref < 2), 32'h1);
		chk(32'(n_pit < 2), 32'h1);
		stop_test();
	end
endmodule : cglps_top_tb
